// ==== sequencer_pkg.sv ====
// Shared constants and types for the program sequencer and return stack
package sequencer_pkg;
  localparam int PC_WIDTH = 12;
  localparam int WORD_WIDTH = 15;
  localparam int DATA_WIDTH = 8;
  localparam int RAM_WORDS = 160;

  // Four system clocks to one instruction cycle
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Fixed vectors
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] VECTOR_EXT = 12'h004;
  localparam logic [11:0] VECTOR_T0 = 12'h008;
  localparam logic [11:0] VECTOR_T1 = 12'h00C;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [3:0] LAST_PAGE = 4'hF;

  // Data space map
  localparam logic [7:0] PCL_OFFSET = 8'h06;
  localparam logic [7:0] TABLE_POINTER_OFFSET = 8'h07;
  localparam logic [7:0] TABLE_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] RAM_FIRST = 8'h60;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] TABLE_POINTER_RESET = 8'h00;
  localparam logic [7:0] TABLE_HIGH_RESET = 8'h00;
  localparam logic [14:0] WORD_RESET = 15'h0000;

  // Return stack
  localparam logic [2:0] STACK_DEPTH = 3'h6;
  localparam logic [2:0] STACK_LAST = 3'h5;
  localparam logic [2:0] STACK_EMPTY = 3'h0;

  // Interrupt sources, reported with the acknowledge
  localparam logic [1:0] SOURCE_EXT = 2'h0;
  localparam logic [1:0] SOURCE_T0 = 2'h1;
  localparam logic [1:0] SOURCE_T1 = 2'h2;

  typedef enum logic [2:0] {
    cmd_none, cmd_jump, cmd_call, cmd_subroutine_exit, cmd_service_exit_reenable,
    cmd_skip, cmd_table_read_current_page, cmd_table_read_last_page
  } cmd_kind_type;

  typedef enum logic [1:0] {run_state, dummy_state, table_state} seq_state_type;

  typedef struct packed {
    cmd_kind_type kind;
    logic [11:0] target;
    logic [7:0] dest;
  } exec_cmd_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage : sequencer_pkg

// ==== program_sequencer_stack.sv ====
// Program counter, fetch pipeline, return stack and table read unit
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps

// How it works
// - Phase counter divides mclk by four; each instruction cycle is four clocks.
// - Fetch overlaps execution; any counter change costs one extra dummy cycle.
// - After each fetched word the program counter steps by one.
// - A taken skip discards the fetched word, runs a dummy cycle, lands at plus two.
// - Writing the low byte register jumps within the current 256-word page.
// - Program memory address comes from counter or table address.
// - Reset clears the program counter to zero.
// - Enabled external request with room on the stack vectors to 004.
// - Enabled first timer request with room on the stack vectors to 008.
// - Enabled second timer request with room on the stack vectors to 00C.
// - Jump and call load all twelve counter bits from the instruction.
// - Current-page table read uses counter page and table pointer.
// - Last-page table read forces page bits to ones.
// - Table read stores low byte at a RAM or table pointer destination, upper bits into table high byte.
// - Table pointer is read/write; table high byte ignores writes.
// - A table read occupies two instruction cycles.
// - Six-entry return stack, hidden from software.
// - Call and acknowledge push the counter; both returns pop it.
// - After reset the stack is empty.
// - While the stack is full no interrupt is acknowledged.
// - Call on a full stack drops the oldest entry, keeping six.
// - Addresses 60 to FF are RAM; unassigned lower addresses read zero.
// - Service exit sets the global enable; plain return leaves it.
// - Simultaneous requests: external, then first timer, then second timer.
module program_sequencer_stack (
  input wire logic mclk,
  input wire logic reset_n,
  input sequencer_pkg::exec_cmd_type cmd,
  input wire logic global_request_enable,
  input wire logic irq_ext_req,
  input wire logic irq_t0_req,
  input wire logic irq_t1_req,
  output logic [11:0] pm_addr,
  input wire logic [14:0] pm_data,
  input sequencer_pkg::reg_req_type reg_bus,
  output logic [7:0] reg_rdata,
  output logic [14:0] instr_word,
  output logic instr_valid,
  output logic cycle_end,
  output logic [1:0] phase,
  output logic irq_ack,
  output logic [1:0] irq_ack_source,
  output logic set_global_request_enable,
  output logic stack_full
);
  logic [1:0] phase_reg;
  logic [11:0] pc_reg;
  logic [11:0] pc_next;
  sequencer_pkg::seq_state_type state_reg;
  sequencer_pkg::seq_state_type state_next;
  logic [14:0] instr_word_reg;
  logic instr_valid_reg;
  logic instr_valid_next;
  logic [7:0] table_pointer_reg;
  logic [7:0] table_high_byte_reg;
  logic [11:0] table_addr_reg;
  logic [7:0] table_dest_reg;
  logic pcl_pending_reg;
  logic [7:0] pcl_value_reg;
  logic [11:0] stack_mem [0:5];
  logic [2:0] stack_ptr_reg;
  logic [2:0] stack_depth_reg;
  logic [7:0] reg_rdata_reg;
  logic irq_ack_reg;
  logic [1:0] irq_ack_source_reg;
  logic reenable_reg;
  logic [7:0] ram [0:159];

  // Instruction cycle boundary
  assign cycle_end = (phase_reg == sequencer_pkg::PHASE_LAST);
  assign phase = phase_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= sequencer_pkg::PHASE_RESET;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Decisions taken at the boundary, in priority order
  wire in_run = cycle_end && (state_reg == sequencer_pkg::run_state);
  wire is_jump = (cmd.kind == sequencer_pkg::cmd_jump);
  wire is_call = (cmd.kind == sequencer_pkg::cmd_call);
  wire is_ret = (cmd.kind == sequencer_pkg::cmd_subroutine_exit);
  wire is_service_exit_reenable = (cmd.kind == sequencer_pkg::cmd_service_exit_reenable);
  wire is_skip = (cmd.kind == sequencer_pkg::cmd_skip);
  wire is_tcur = (cmd.kind == sequencer_pkg::cmd_table_read_current_page);
  wire is_tlast = (cmd.kind == sequencer_pkg::cmd_table_read_last_page);
  wire is_none = (cmd.kind == sequencer_pkg::cmd_none);
  wire take_jump = in_run && (is_jump || is_call);
  wire take_ret = in_run && (is_ret || is_service_exit_reenable);
  wire take_skip = in_run && is_skip;
  wire table_start = in_run && (is_tcur || is_tlast);
  wire take_pcl = in_run && is_none && pcl_pending_reg;
  wire any_req = irq_ext_req || irq_t0_req || irq_t1_req;
  // Held requests wait while full; a pop frees a level for them
  wire irq_take = in_run && is_none && !pcl_pending_reg && global_request_enable
    && any_req && !stack_full;
  wire normal_step = cycle_end && !take_jump && !take_ret && !take_skip
    && !table_start && !take_pcl && !irq_take
    && (state_reg != sequencer_pkg::table_state);
  wire table_finish = cycle_end && (state_reg == sequencer_pkg::table_state);
  wire do_push = irq_take || (take_jump && is_call);
  wire do_pop = take_ret;

  // Fixed priority among simultaneous requests
  wire [11:0] irq_vector = irq_ext_req ? sequencer_pkg::VECTOR_EXT :
    irq_t0_req ? sequencer_pkg::VECTOR_T0 :
    sequencer_pkg::VECTOR_T1;
  wire [1:0] irq_source = irq_ext_req ? sequencer_pkg::SOURCE_EXT :
    irq_t0_req ? sequencer_pkg::SOURCE_T0 : sequencer_pkg::SOURCE_T1;

  // Return stack as a ring; a push when full overwrites the oldest slot
  wire [2:0] ptr_up = (stack_ptr_reg == sequencer_pkg::STACK_LAST) ? 3'h0
    : stack_ptr_reg + 3'h1;
  wire [2:0] ptr_down = (stack_ptr_reg == 3'h0) ? sequencer_pkg::STACK_LAST
    : stack_ptr_reg - 3'h1;
  wire [11:0] stack_top = stack_mem[ptr_down];
  assign stack_full = (stack_depth_reg == sequencer_pkg::STACK_DEPTH);

  // Table address
  wire [3:0] table_page = is_tlast ? sequencer_pkg::LAST_PAGE
    : pc_reg[11:8];
  wire [11:0] table_addr = {table_page, table_pointer_reg};

  always_comb begin
    pc_next = pc_reg;
    state_next = state_reg;
    instr_valid_next = instr_valid_reg;
    if (take_jump) begin
      pc_next = cmd.target;
    end else if (take_ret) begin
      pc_next = stack_top;
    end else if (take_skip) begin
      pc_next = pc_reg + sequencer_pkg::PC_STEP;
    end else if (take_pcl) begin
      pc_next = {pc_reg[11:8], pcl_value_reg};
    end else if (irq_take) begin
      pc_next = irq_vector;
    end else if (table_start) begin
      pc_next = pc_reg + sequencer_pkg::PC_STEP;
    end else if (normal_step) begin
      pc_next = pc_reg + sequencer_pkg::PC_STEP;
    end
    if (cycle_end) begin
      case (state_reg)
        sequencer_pkg::run_state: begin
          if (table_start) begin
            state_next = sequencer_pkg::table_state;
            instr_valid_next = 1'b0;
          end else if (normal_step) begin
            instr_valid_next = 1'b1;
          end else begin
            state_next = sequencer_pkg::dummy_state;
            instr_valid_next = 1'b0;
          end
        end
        sequencer_pkg::dummy_state: begin
          state_next = sequencer_pkg::run_state;
          instr_valid_next = 1'b1;
        end
        sequencer_pkg::table_state: begin
          state_next = sequencer_pkg::run_state;
          instr_valid_next = 1'b1;
        end
        default: begin
          state_next = sequencer_pkg::run_state;
          instr_valid_next = 1'b0;
        end
      endcase
    end
  end

  // Memory is read by the table address only in the second table cycle
  assign pm_addr = (state_reg == sequencer_pkg::table_state) ? table_addr_reg
    : pc_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= sequencer_pkg::PC_RESET;
      state_reg <= sequencer_pkg::run_state;
      instr_valid_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      state_reg <= state_next;
      instr_valid_reg <= instr_valid_next;
    end
  end

  // Fetched word held unchanged across the table cycle
  // Table start also takes the next word, else the table instruction would run twice
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      instr_word_reg <= sequencer_pkg::WORD_RESET;
    end else if (normal_step || table_start) begin
      instr_word_reg <= pm_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      table_addr_reg <= sequencer_pkg::PC_RESET;
      table_dest_reg <= sequencer_pkg::UNMAPPED_VALUE;
    end else if (table_start) begin
      table_addr_reg <= table_addr;
      table_dest_reg <= cmd.dest;
    end
  end

  // Stack storage, not reachable from the data bus
  always_ff @(posedge mclk) begin
    if (do_push) begin
      stack_mem[stack_ptr_reg] <= pc_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr_reg <= sequencer_pkg::STACK_EMPTY;
      stack_depth_reg <= sequencer_pkg::STACK_EMPTY;
    end else if (do_push) begin
      stack_ptr_reg <= ptr_up;
      if (!stack_full) begin
        stack_depth_reg <= stack_depth_reg + 3'h1;
      end
    end else if (do_pop) begin
      stack_ptr_reg <= ptr_down;
      if (stack_depth_reg != sequencer_pkg::STACK_EMPTY) begin
        stack_depth_reg <= stack_depth_reg - 3'h1;
      end
    end
  end

  // Register port decode
  wire wr_pcl = reg_bus.wr && (reg_bus.addr == sequencer_pkg::PCL_OFFSET);
  wire wr_table_pointer = reg_bus.wr && (reg_bus.addr == sequencer_pkg::TABLE_POINTER_OFFSET);
  wire bus_ram = (reg_bus.addr >= sequencer_pkg::RAM_FIRST);
  wire table_ram = (table_dest_reg >= sequencer_pkg::RAM_FIRST);
  wire table_table_pointer = (table_dest_reg == sequencer_pkg::TABLE_POINTER_OFFSET);
  wire ram_we = (table_finish && table_ram) || (reg_bus.wr && bus_ram);
  wire [7:0] ram_waddr = (table_finish && table_ram) ? table_dest_reg - sequencer_pkg::RAM_FIRST
    : reg_bus.addr - sequencer_pkg::RAM_FIRST;
  wire [7:0] ram_wdata = (table_finish && table_ram) ? pm_data[7:0] : reg_bus.wdata;
  wire [7:0] ram_raddr = reg_bus.addr - sequencer_pkg::RAM_FIRST;
  wire [7:0] read_value = bus_ram ? ram[ram_raddr]
    : (reg_bus.addr == sequencer_pkg::PCL_OFFSET) ? pc_reg[7:0]
    : (reg_bus.addr == sequencer_pkg::TABLE_POINTER_OFFSET) ? table_pointer_reg
    : (reg_bus.addr == sequencer_pkg::TABLE_HIGH_OFFSET) ? table_high_byte_reg
    : sequencer_pkg::UNMAPPED_VALUE;

  always_ff @(posedge mclk) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  // A new write beats consumption of an older pending short jump
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pcl_pending_reg <= 1'b0;
      pcl_value_reg <= sequencer_pkg::UNMAPPED_VALUE;
    end else if (wr_pcl) begin
      pcl_pending_reg <= 1'b1;
      pcl_value_reg <= reg_bus.wdata;
    end else if (take_pcl) begin
      pcl_pending_reg <= 1'b0;
    end
  end

  // Table high byte has no bus write path
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      table_pointer_reg <= sequencer_pkg::TABLE_POINTER_RESET;
      table_high_byte_reg <= sequencer_pkg::TABLE_HIGH_RESET;
    end else begin
      if (table_finish) begin
        table_high_byte_reg <= {1'b0, pm_data[14:8]};
      end
      if (table_finish && table_table_pointer) begin
        table_pointer_reg <= pm_data[7:0];
      end else if (wr_table_pointer) begin
        table_pointer_reg <= reg_bus.wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_reg <= sequencer_pkg::UNMAPPED_VALUE;
      irq_ack_reg <= 1'b0;
      irq_ack_source_reg <= sequencer_pkg::SOURCE_EXT;
      reenable_reg <= 1'b0;
    end else begin
      reg_rdata_reg <= reg_bus.rd ? read_value : sequencer_pkg::UNMAPPED_VALUE;
      irq_ack_reg <= irq_take;
      if (irq_take) begin
        irq_ack_source_reg <= irq_source;
      end
      reenable_reg <= take_ret && is_service_exit_reenable;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign instr_word = instr_word_reg;
  assign instr_valid = instr_valid_reg;
  assign irq_ack = irq_ack_reg;
  assign irq_ack_source = irq_ack_source_reg;
  assign set_global_request_enable = reenable_reg;

  a_phase_period: assert property (@(posedge mclk) disable iff (!reset_n)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
  a_pc_reset_start: assert property (@(posedge mclk)
    $rose(reset_n) |-> pc_reg == sequencer_pkg::PC_RESET)
    else $error("counter not zero after reset");
  a_pc_step_one: assert property (@(posedge mclk) disable iff (!reset_n)
    normal_step |=> pc_reg == $past(pc_reg) + sequencer_pkg::PC_STEP && instr_valid)
    else $error("counter did not step by one");
  a_skip_dummy_two: assert property (@(posedge mclk) disable iff (!reset_n)
    take_skip |=> !instr_valid && pc_reg == $past(pc_reg) + sequencer_pkg::PC_STEP
    ##4 pc_reg == $past(pc_reg, 5) + 12'h002)
    else $error("skip did not land at plus two");
  a_jump_load_all: assert property (@(posedge mclk) disable iff (!reset_n)
    take_jump |=> pc_reg == $past(cmd.target) && !instr_valid)
    else $error("jump target not loaded");
  a_short_jump_page: assert property (@(posedge mclk) disable iff (!reset_n)
    take_pcl |=> pc_reg == {$past(pc_reg[11:8]), $past(pcl_value_reg)})
    else $error("short jump left its page");
  a_irq_ext_first: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_take && irq_ext_req |=> pc_reg == sequencer_pkg::VECTOR_EXT && irq_ack)
    else $error("external vector wrong");
  a_irq_t1_last: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_take && !irq_ext_req && !irq_t0_req |=> pc_reg == sequencer_pkg::VECTOR_T1)
    else $error("second timer vector wrong");
  a_full_no_ack: assert property (@(posedge mclk) disable iff (!reset_n)
    stack_full && in_run |=> !irq_ack)
    else $error("acknowledge while stack full");
  a_table_two_cycles: assert property (@(posedge mclk) disable iff (!reset_n)
    table_start |=> (state_reg == sequencer_pkg::table_state) [*4]
    ##1 state_reg == sequencer_pkg::run_state && instr_valid)
    else $error("table read not two cycles");
  a_table_high_load: assert property (@(posedge mclk) disable iff (!reset_n)
    table_finish |=> table_high_byte_reg == {1'b0, $past(pm_data[14:8])})
    else $error("table high byte not loaded");
  a_return_pop: assert property (@(posedge mclk) disable iff (!reset_n)
    take_ret |=> pc_reg == $past(stack_top) && set_global_request_enable == $past(is_service_exit_reenable))
    else $error("return pop or enable wrong");
  a_depth_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    stack_full && do_push |=> stack_full)
    else $error("overflow changed depth");
  a_irq_t0_second: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_take && !irq_ext_req && irq_t0_req |=> pc_reg == sequencer_pkg::VECTOR_T0)
    else $error("first timer vector wrong");
  a_table_next_fetch: assert property (@(posedge mclk) disable iff (!reset_n)
    table_start |=> pc_reg == $past(pc_reg) + sequencer_pkg::PC_STEP
    && instr_word == $past(pm_data))
    else $error("table start lost the next word");
  a_read_idle_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_bus.rd |=> reg_rdata == sequencer_pkg::UNMAPPED_VALUE)
    else $error("read data not zero without a read");

  c_call_push: cover property (@(posedge mclk) disable iff (!reset_n)
    take_jump && is_call);
  c_irq_taken: cover property (@(posedge mclk) disable iff (!reset_n) irq_take);
  c_table_done: cover property (@(posedge mclk) disable iff (!reset_n) table_finish);
  c_overflow: cover property (@(posedge mclk) disable iff (!reset_n)
    stack_full && do_push);
  c_skip_taken: cover property (@(posedge mclk) disable iff (!reset_n)
    take_skip);
endmodule : program_sequencer_stack

// ==== program_source_model.sv ====
// Program memory and interrupt request source facing the sequencer
`timescale 1ns/100ps
module program_source_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] pm_addr,
  output logic [14:0] pm_data,
  input wire logic irq_ack,
  input wire logic [1:0] irq_ack_source,
  input wire logic set_global_request_enable,
  input wire logic [2:0] raise,
  input wire logic enable_all,
  output logic global_request_enable,
  output logic [2:0] pending_reg
);
  // Word tied to its address so any wrong fetch address shows up
  assign pm_data = {pm_addr[2:0] ^ 3'h5, pm_addr};
  // Flags stay recorded until acknowledged, even while the stack is full
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 3'h0;
      global_request_enable <= 1'b0;
    end else begin
      pending_reg <= (pending_reg | raise) & ~({2'h0, irq_ack} << irq_ack_source);
      global_request_enable <= (global_request_enable | enable_all | set_global_request_enable)
                               & ~irq_ack;
    end
  end
endmodule : program_source_model

// ==== tb.sv ====
// Self-checking bench for the program sequencer and return stack
`timescale 1ns/100ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  sequencer_pkg::exec_cmd_type cmd = '0;
  sequencer_pkg::reg_req_type reg_bus = '0;
  logic [2:0] raise = 3'h0;
  logic enable_all = 1'b0;
  logic ge;
  logic [2:0] pending;
  logic [11:0] pm_addr;
  logic [14:0] pm_data;
  logic [7:0] reg_rdata;
  logic [14:0] instr_word;
  logic instr_valid, cycle_end, irq_ack, set_ge, stack_full, seen;
  logic [1:0] phase;
  logic [1:0] ack_source;
  logic [11:0] boundary_pc, pre_pc, rd_pc, exp_pc, tgt;
  logic [7:0] rd_data;
  logic [14:0] word_exp;
  logic [11:0] ref_stack[$];
  int miscompares = 0;
  int n_tests = 0;
  int gap = 1;
  int reenable_count = 0;
  int count0;

  program_sequencer_stack program_sequencer_stack_inst (
    .mclk(mclk), .reset_n(reset_n), .cmd(cmd), .global_request_enable(ge),
    .irq_ext_req(pending[0]), .irq_t0_req(pending[1]), .irq_t1_req(pending[2]),
    .pm_addr(pm_addr), .pm_data(pm_data), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
    .instr_word(instr_word), .instr_valid(instr_valid), .cycle_end(cycle_end),
    .phase(phase), .irq_ack(irq_ack), .irq_ack_source(ack_source),
    .set_global_request_enable(set_ge), .stack_full(stack_full));

  program_source_model program_source_model_inst (
    .mclk(mclk), .reset_n(reset_n), .pm_addr(pm_addr), .pm_data(pm_data),
    .irq_ack(irq_ack), .irq_ack_source(ack_source), .set_global_request_enable(set_ge),
    .raise(raise), .enable_all(enable_all), .global_request_enable(ge),
    .pending_reg(pending));

  initial begin
    forever #10 mclk = ~mclk;
  end

  function automatic logic [14:0] rom_word(input logic [11:0] a);
    return {a[2:0] ^ 3'h5, a};
  endfunction : rom_word

  // Pc at each boundary, so an interrupt's pushed address is known
  always @(posedge mclk) begin
    if (phase == 2'h3) boundary_pc <= pm_addr;
    if (set_ge === 1'b1) reenable_count <= reenable_count + 1;
    if (reset_n && cycle_end === 1'b1) `CHECK(gap, 4)
    gap <= (!reset_n || cycle_end === 1'b1) ? 1 : gap + 1;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_bus <= '0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    reg_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_bus <= '0;
    rd_pc = pm_addr;
    #1 rd_data = reg_rdata;
  endtask : reg_read

  // Command stands only in the boundary cycle of a valid instruction
  task automatic exec(input sequencer_pkg::cmd_kind_type k, input logic [11:0] t,
                      input logic [7:0] d);
    do @(posedge mclk); while (!(phase == 2'h2 && instr_valid === 1'b1));
    cmd <= '{kind: k, target: t, dest: d};
    @(posedge mclk);
    cmd <= '0;
    pre_pc = pm_addr;
    if (k == sequencer_pkg::cmd_call) begin
      ref_stack.push_front(pm_addr);
      if (ref_stack.size() > 6) void'(ref_stack.pop_back());
    end
    #1;
  endtask : exec

  task automatic wait_boundary;
    do @(posedge mclk); while (phase !== 2'h3);
    #1;
  endtask : wait_boundary

  task automatic wait_ack;
    seen = 1'b0;
    for (int i = 0; i < 24 && seen !== 1'b1; i++) begin
      @(posedge mclk);
      #1 seen = irq_ack;
    end
  endtask : wait_ack

  task automatic take_irq(input logic [1:0] src, input logic [11:0] vec);
    wait_ack();
    `CHECK(seen, 1'b1)
    `CHECK(ack_source, src)
    `CHECK(pm_addr, vec)
    ref_stack.push_front(boundary_pc);
  endtask : take_irq

  task automatic ret_check(input sequencer_pkg::cmd_kind_type k);
    exec(k, 12'h000, 8'h00);
    exp_pc = ref_stack.pop_front();
    `CHECK(pm_addr, exp_pc)
  endtask : ret_check

  task automatic table_case(input sequencer_pkg::cmd_kind_type k, input logic [7:0] dest);
    logic [3:0] page;
    exec(k, 12'h000, dest);
    page = (k == sequencer_pkg::cmd_table_read_last_page) ? 4'hF : pre_pc[11:8];
    word_exp = rom_word({page, 8'h5C});
    `CHECK(pm_addr, {page, 8'h5C})
    `CHECK(instr_valid, 1'b0)
    wait_boundary();
    `CHECK(pm_addr, pre_pc + 12'h001)
    `CHECK(instr_word, rom_word(pre_pc))
    `CHECK(instr_valid, 1'b1)
    reg_read(dest);
    `CHECK(rd_data, word_exp[7:0])
    reg_read(sequencer_pkg::TABLE_HIGH_OFFSET);
    `CHECK(rd_data, {1'b0, word_exp[14:8]})
  endtask : table_case

  initial begin
    repeat (3) @(posedge mclk);
    `CHECK(pm_addr, 12'h000)
    `CHECK(stack_full, 1'b0)
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHECK(instr_word, rom_word(12'h000))
    `CHECK(pm_addr, 12'h001)
    exec(sequencer_pkg::cmd_jump, 12'h3A5, 8'h00);
    `CHECK(pm_addr, 12'h3A5)
    `CHECK(instr_valid, 1'b0)
    wait_boundary();
    `CHECK(instr_word, rom_word(12'h3A5))
    `CHECK(pm_addr, 12'h3A6)
    exec(sequencer_pkg::cmd_skip, 12'h000, 8'h00);
    `CHECK(pm_addr, pre_pc + 12'h001)
    wait_boundary();
    `CHECK(instr_word, rom_word(pre_pc + 12'h001))
    reg_write(8'h07, 8'h5C);
    reg_read(8'h07);
    `CHECK(rd_data, 8'h5C)
    reg_write(8'h08, 8'h33);
    reg_read(8'h08);
    `CHECK(rd_data, 8'h00)
    reg_read(8'h20);
    `CHECK(rd_data, 8'h00)
    reg_read(8'h06);
    `CHECK(rd_data, rd_pc[7:0])
    reg_write(8'h9F, 8'hA6);
    reg_read(8'h9F);
    `CHECK(rd_data, 8'hA6)
    @(posedge mclk);
    #1;
    `CHECK(reg_rdata, 8'h00)
    table_case(sequencer_pkg::cmd_table_read_current_page, 8'h70);
    table_case(sequencer_pkg::cmd_table_read_last_page, 8'h07);
    exec(sequencer_pkg::cmd_none, 12'h000, 8'h00);
    reg_write(8'h06, 8'h40);
    wait_boundary();
    `CHECK(pm_addr, {pre_pc[11:8], 8'h40})
    `CHECK(instr_valid, 1'b0)
    // Seventh call overflows the six-entry stack
    for (int i = 0; i < 7; i++) begin
      tgt = 12'h100 + 12'(i) * 12'h010;
      exec(sequencer_pkg::cmd_call, tgt, 8'h00);
      `CHECK(pm_addr, tgt)
      `CHECK(stack_full, 1'(i >= 5))
    end
    @(posedge mclk);
    raise <= 3'h7;
    enable_all <= 1'b1;
    @(posedge mclk);
    raise <= 3'h0;
    enable_all <= 1'b0;
    wait_ack();
    `CHECK(seen, 1'b0)
    ret_check(sequencer_pkg::cmd_subroutine_exit);
    take_irq(sequencer_pkg::SOURCE_EXT, sequencer_pkg::VECTOR_EXT);
    count0 = reenable_count;
    ret_check(sequencer_pkg::cmd_service_exit_reenable);
    take_irq(sequencer_pkg::SOURCE_T0, sequencer_pkg::VECTOR_T0);
    `CHECK(reenable_count, count0 + 1)
    ret_check(sequencer_pkg::cmd_subroutine_exit);
    wait_ack();
    `CHECK(seen, 1'b0)
    `CHECK(reenable_count, count0 + 1)
    ret_check(sequencer_pkg::cmd_service_exit_reenable);
    take_irq(sequencer_pkg::SOURCE_T1, sequencer_pkg::VECTOR_T1);
    while (ref_stack.size() > 0) ret_check(sequencer_pkg::cmd_subroutine_exit);
    `CHECK(stack_full, 1'b0)
    report_and_stop();
  end

  // Whole sequence needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
endmodule : tb
